/* verilog/csrb_pkg.sv */
/*
  Shared definitions of the colour sensor register bank: register indices,
  field positions, reset values, state encoding and the carrier structs.
  Imported by the register bank top, its checker, the front end model and the bench.
*/
`default_nettype none

package csrb_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [6:0] IDX_CONVERSION_CONTROL  = 7'h00;
  localparam logic [6:0] IDX_MODE_CONFIGURATION  = 7'h01;
  localparam logic [6:0] IDX_RED_GAIN_SETTING    = 7'h06;
  localparam logic [6:0] IDX_GREEN_GAIN_SETTING  = 7'h07;
  localparam logic [6:0] IDX_BLUE_GAIN_SETTING   = 7'h08;
  localparam logic [6:0] IDX_CLEAR_GAIN_SETTING  = 7'h09;
  localparam logic [6:0] IDX_RED_INTEGRATION_LOW = 7'h0A;
  localparam logic [6:0] IDX_CLEAR_INTEGRATION_HIGH = 7'h11;
  localparam logic [6:0] IDX_RED_RESULT_LOW      = 7'h40;
  localparam logic [6:0] IDX_CLEAR_RESULT_HIGH   = 7'h47;
  localparam logic [6:0] IDX_RED_OFFSET_VALUE    = 7'h48;
  localparam logic [6:0] IDX_CLEAR_OFFSET_VALUE  = 7'h4B;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int POS_START_COLOUR_CONVERSION = 0;
  localparam int POS_START_OFFSET_MEASURE    = 1;
  localparam int POS_OFFSET_TRIM_ENABLE      = 0;
  localparam int POS_SLEEP                   = 1;
  localparam int POS_EXTERNAL_TIMEBASE       = 2;
  localparam int POS_OFFSET_SIGN             = 7;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int NUM_CHANNELS   = 4;
  localparam int CAP_W          = 4;
  localparam int SLOT_W         = 12;
  localparam int RESULT_W       = 10;
  localparam int OFFSET_W       = 8;
  localparam logic [3:0]  RST_CAPACITOR_COUNT = 4'hF;
  localparam logic [11:0] RST_SLOT_COUNT      = 12'h000;
  localparam logic [9:0]  RST_RESULT          = 10'h000;
  localparam logic [7:0]  RST_OFFSET          = 8'h00;
  localparam logic [9:0]  RESULT_MAX          = 10'h3FF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_COLOUR, ST_OFFSET} csrb_state_t;

  // Channel order in every struct: red, green, blue, clear
  typedef struct packed {
    logic [RESULT_W-1:0] red;
    logic [RESULT_W-1:0] green;
    logic [RESULT_W-1:0] blue;
    logic [RESULT_W-1:0] clear;
  } csrb_result_t;

  typedef struct packed {
    logic [OFFSET_W-1:0] red;
    logic [OFFSET_W-1:0] green;
    logic [OFFSET_W-1:0] blue;
    logic [OFFSET_W-1:0] clear;
  } csrb_offset_t;

  typedef struct packed {
    logic [CAP_W-1:0] red;
    logic [CAP_W-1:0] green;
    logic [CAP_W-1:0] blue;
    logic [CAP_W-1:0] clear;
  } csrb_gain_t;

  typedef struct packed {
    logic [SLOT_W-1:0] red;
    logic [SLOT_W-1:0] green;
    logic [SLOT_W-1:0] blue;
    logic [SLOT_W-1:0] clear;
  } csrb_slots_t;

endpackage

`default_nettype wire

/* verilog/csrb_top.sv */
/*
  Colour sensor register bank with conversion control, reached over
  AHB-Lite. Assumes a front end on the same clock that runs a measurement
  while MEAS_REQ_OUT is high and answers with a one-cycle MEAS_DONE_IN
  carrying its results; the analog part itself lives outside this block.
*/
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
//   Contract
//   - Writing one to colour trigger starts conversion; results fill indices 64-71.
//   - Offset trigger at bit 1 is active high, clears itself when done.
//   - Offset results land in indices 72-75.
//   - Colour trigger is active high and self-clearing; no zero write needed.
//   - Configuration bit 2 set selects external timebase mode.
//   - Sleep bit 1 holds only in external mode, else cleared by hardware.
//   - Configuration bit 0 enables offset trim on channel readings.
//   - Each channel has a 4-bit capacitor count in bits 3:0.
//   - Twelve-bit slot count: bits 7:0 low byte, 11:8 high nibble.
//   - Ten-bit result: bits 7:0 low byte, 9:8 in high byte.
//   - Offset holds sign in bit 7, magnitude in 6:0; one means negative.
`timescale 1ns/1ps
`default_nettype none

module csrb_top
  import csrb_pkg::*;
(
  input  wire logic         CLK_SYS_IN,
  input  wire logic         RESETN_IN,
  // AHB-Lite slave
  input  wire logic         HSEL_IN,
  input  wire logic [31:0]  HADDR_IN,
  input  wire logic [1:0]   HTRANS_IN,
  input  wire logic         HWRITE_IN,
  input  wire logic [2:0]   HSIZE_IN,
  input  wire logic         HREADY_IN,
  input  wire logic [31:0]  HWDATA_IN,
  output logic [31:0]       HRDATA_OUT,
  output logic              HREADYOUT_OUT,
  output logic              HRESP_OUT,
  // Front end
  output logic              MEAS_REQ_OUT,
  output logic              MEAS_OFFSET_OUT,
  input  wire logic         MEAS_DONE_IN,
  input  wire csrb_result_t MEAS_RESULT_IN,
  input  wire csrb_offset_t MEAS_OFFSET_IN,
  output csrb_gain_t        GAIN_OUT,
  output csrb_slots_t       SLOTS_OUT,
  output logic              EXT_TIMEBASE_OUT,
  output logic              SLEEP_OUT,
  output logic              TRIM_ENABLE_OUT
);

  // -----------------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------------
  logic [CAP_W-1:0]    cap_q    [NUM_CHANNELS];
  logic [SLOT_W-1:0]   slot_q   [NUM_CHANNELS];
  logic [RESULT_W-1:0] result_q [NUM_CHANNELS];
  logic [OFFSET_W-1:0] offset_q [NUM_CHANNELS];
  logic                colour_go_q;
  logic                offset_go_q;
  logic                ext_q;
  logic                sleep_q;
  logic                trim_q;
  csrb_state_t         state_q;
  logic                req_q;
  logic                req_offset_q;

  // -----------------------------------------------------------------------
  // Bus slave
  // -----------------------------------------------------------------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [6:0]  addr_idx_q;
  logic        addr_ok_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  logic        addr_phase;
  logic        addr_ok;
  logic        wr_commit;
  logic [7:0]  wbyte;

  assign addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign addr_ok    = (HADDR_IN[31:9] == 23'h000000) && (HADDR_IN[1:0] == 2'b00);
  assign wr_commit  = wr_pend_q && HREADY_IN && addr_ok_q;
  assign wbyte      = HWDATA_IN[7:0];

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
      addr_idx_q <= 7'h00;
      addr_ok_q  <= 1'b0;
      ready_q    <= 1'b1;
    end else begin
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        ready_q   <= 1'b1;
      end else if (HREADY_IN) begin
        wr_pend_q <= addr_phase && HWRITE_IN;
        rd_pend_q <= addr_phase && !HWRITE_IN;
        ready_q   <= !(addr_phase && !HWRITE_IN);
        if (addr_phase) begin
          addr_idx_q <= HADDR_IN[8:2];
          addr_ok_q  <= addr_ok;
        end
      end
    end
  end

  // Read mux; unavailable bits and unmapped indices give zero
  function automatic logic [7:0] read_byte(input logic [6:0] idx);
    logic [7:0] v;
    logic [1:0] ch;
    v  = 8'h00;
    ch = 2'(idx[1:0]);
    if (idx == IDX_CONVERSION_CONTROL) begin
      v[POS_START_COLOUR_CONVERSION] = colour_go_q;
      v[POS_START_OFFSET_MEASURE]    = offset_go_q;
    end else if (idx == IDX_MODE_CONFIGURATION) begin
      v[POS_OFFSET_TRIM_ENABLE] = trim_q;
      v[POS_SLEEP]              = sleep_q;
      v[POS_EXTERNAL_TIMEBASE]  = ext_q;
    end else if (idx >= IDX_RED_GAIN_SETTING && idx <= IDX_CLEAR_GAIN_SETTING) begin
      v = {4'h0, cap_q[2'(idx - IDX_RED_GAIN_SETTING)]};
    end else if (idx >= IDX_RED_INTEGRATION_LOW && idx <= IDX_CLEAR_INTEGRATION_HIGH) begin
      ch = 2'((idx - IDX_RED_INTEGRATION_LOW) >> 1);
      v  = idx[0] ? {4'h0, slot_q[ch][11:8]} : slot_q[ch][7:0];
    end else if (idx >= IDX_RED_RESULT_LOW && idx <= IDX_CLEAR_RESULT_HIGH) begin
      ch = 2'((idx - IDX_RED_RESULT_LOW) >> 1);
      v  = idx[0] ? {6'h00, result_q[ch][9:8]} : result_q[ch][7:0];
    end else if (idx >= IDX_RED_OFFSET_VALUE && idx <= IDX_CLEAR_OFFSET_VALUE) begin
      v = offset_q[2'(idx - IDX_RED_OFFSET_VALUE)];
    end
    return v;
  endfunction

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      rdata_q <= addr_ok_q ? {24'h000000, read_byte(addr_idx_q)} : 32'h00000000;
    end
  end

  // -----------------------------------------------------------------------
  // Configuration
  // -----------------------------------------------------------------------
  logic cfg_wr;
  assign cfg_wr = wr_commit && (addr_idx_q == IDX_MODE_CONFIGURATION);

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ext_q   <= 1'b0;
      sleep_q <= 1'b0;
      trim_q  <= 1'b0;
    end else if (cfg_wr) begin
      ext_q   <= wbyte[POS_EXTERNAL_TIMEBASE];
      sleep_q <= wbyte[POS_SLEEP] && wbyte[POS_EXTERNAL_TIMEBASE];
      trim_q  <= wbyte[POS_OFFSET_TRIM_ENABLE];
    end else if (!ext_q) begin
      sleep_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Gain and integration settings
  // -----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        cap_q[i]  <= RST_CAPACITOR_COUNT;
        slot_q[i] <= RST_SLOT_COUNT;
      end
    end else if (wr_commit) begin
      if (addr_idx_q >= IDX_RED_GAIN_SETTING && addr_idx_q <= IDX_CLEAR_GAIN_SETTING) begin
        cap_q[2'(addr_idx_q - IDX_RED_GAIN_SETTING)] <= wbyte[3:0];
      end
      if (addr_idx_q >= IDX_RED_INTEGRATION_LOW
          && addr_idx_q <= IDX_CLEAR_INTEGRATION_HIGH) begin
        if (addr_idx_q[0]) begin
          slot_q[2'((addr_idx_q - IDX_RED_INTEGRATION_LOW) >> 1)][11:8] <= wbyte[3:0];
        end else begin
          slot_q[2'((addr_idx_q - IDX_RED_INTEGRATION_LOW) >> 1)][7:0] <= wbyte;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Trigger bits
  // -----------------------------------------------------------------------
  logic ctrl_wr;
  logic colour_done;
  logic offset_done;
  assign ctrl_wr     = wr_commit && (addr_idx_q == IDX_CONVERSION_CONTROL);
  assign colour_done = (state_q == ST_COLOUR) && MEAS_DONE_IN;
  assign offset_done = (state_q == ST_OFFSET) && MEAS_DONE_IN;

  // A one written in the finishing cycle wins and queues a fresh run;
  // a zero write cannot abort a run in progress
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      colour_go_q <= 1'b0;
      offset_go_q <= 1'b0;
    end else begin
      colour_go_q <= (colour_go_q && !colour_done)
                     || (ctrl_wr && wbyte[POS_START_COLOUR_CONVERSION]);
      offset_go_q <= (offset_go_q && !offset_done)
                     || (ctrl_wr && wbyte[POS_START_OFFSET_MEASURE]);
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  // Colour first when both are pending; nothing starts while asleep
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q      <= ST_IDLE;
      req_q        <= 1'b0;
      req_offset_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (colour_go_q && !sleep_q) begin
            state_q      <= ST_COLOUR;
            req_q        <= 1'b1;
            req_offset_q <= 1'b0;
          end else if (offset_go_q && !sleep_q) begin
            state_q      <= ST_OFFSET;
            req_q        <= 1'b1;
            req_offset_q <= 1'b1;
          end
        end
        ST_COLOUR, ST_OFFSET: begin
          if (MEAS_DONE_IN) begin
            state_q <= ST_IDLE;
            req_q   <= 1'b0;
          end
        end
        // The fourth code of the state word is illegal; fall back to idle
        default: begin
          state_q <= ST_IDLE;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Results
  // -----------------------------------------------------------------------
  // Saturating correction keeps a large negative offset from wrapping
  function automatic logic [RESULT_W-1:0] trimmed(input logic [RESULT_W-1:0] raw,
                                                  input logic [OFFSET_W-1:0] ofs);
    logic signed [12:0] s;
    s = $signed({3'b000, raw});
    if (ofs[POS_OFFSET_SIGN]) begin
      s = s + $signed({6'h00, ofs[6:0]});
    end else begin
      s = s - $signed({6'h00, ofs[6:0]});
    end
    if (s < 0) begin
      return RST_RESULT;
    end else if (s > $signed({3'b000, RESULT_MAX})) begin
      return RESULT_MAX;
    end
    return s[RESULT_W-1:0];
  endfunction

  logic [RESULT_W-1:0] raw_v [NUM_CHANNELS];
  logic [OFFSET_W-1:0] ofs_v [NUM_CHANNELS];
  assign raw_v[0] = MEAS_RESULT_IN.red;
  assign raw_v[1] = MEAS_RESULT_IN.green;
  assign raw_v[2] = MEAS_RESULT_IN.blue;
  assign raw_v[3] = MEAS_RESULT_IN.clear;
  assign ofs_v[0] = MEAS_OFFSET_IN.red;
  assign ofs_v[1] = MEAS_OFFSET_IN.green;
  assign ofs_v[2] = MEAS_OFFSET_IN.blue;
  assign ofs_v[3] = MEAS_OFFSET_IN.clear;

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result_q[i] <= RST_RESULT;
      end
    end else if (colour_done) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result_q[i] <= trim_q ? trimmed(raw_v[i], offset_q[i]) : raw_v[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        offset_q[i] <= RST_OFFSET;
      end
    end else if (offset_done) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        offset_q[i] <= ofs_v[i];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign HRDATA_OUT       = rdata_q;
  assign HREADYOUT_OUT    = ready_q;
  assign HRESP_OUT        = 1'b0;
  assign MEAS_REQ_OUT     = req_q;
  assign MEAS_OFFSET_OUT  = req_offset_q;
  assign EXT_TIMEBASE_OUT = ext_q;
  assign SLEEP_OUT        = sleep_q;
  assign TRIM_ENABLE_OUT  = trim_q;
  assign GAIN_OUT         = '{red: cap_q[0], green: cap_q[1], blue: cap_q[2], clear: cap_q[3]};
  assign SLOTS_OUT        = '{red: slot_q[0], green: slot_q[1], blue: slot_q[2],
                              clear: slot_q[3]};

endmodule // csrb_top

`default_nettype wire

/* sim/csrb_top_assertions.sv */
/*
  Checker for the colour sensor register bank: bus timing, run handshake,
  mode bits. Assumes HREADY_IN is tied to HREADYOUT_OUT and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module csrb_top_assertions
  import csrb_pkg::*;
(
  input wire logic        CLK_SYS_IN,
  input wire logic        RESETN_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        MEAS_REQ_OUT,
  input wire logic        MEAS_OFFSET_OUT,
  input wire logic        MEAS_DONE_IN,
  input wire csrb_gain_t  GAIN_OUT,
  input wire logic        EXT_TIMEBASE_OUT,
  input wire logic        SLEEP_OUT,
  input wire logic        TRIM_ENABLE_OUT
);
  // ---------------------------------------------------------------------
  // Address phase capture
  // ---------------------------------------------------------------------
  logic       ap_q;
  logic       wr_q;
  logic [6:0] idx_q;
  logic       take;
  assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  // Unmapped addresses get an index no register owns
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ap_q  <= 1'b0;
      wr_q  <= 1'b0;
      idx_q <= 7'h7F;
    end else begin
      ap_q  <= take;
      wr_q  <= HWRITE_IN;
      idx_q <= (HADDR_IN[31:9] == 23'h0 && HADDR_IN[1:0] == 2'h0) ? HADDR_IN[8:2] : 7'h7F;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence rd_wait_s;
    !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endsequence
  sequence cfg_wr_s;
    ap_q && wr_q && idx_q == 7'h01;
  endsequence

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  colour_start_a: assert property (
    (ap_q && wr_q && idx_q == 7'h00 && HWDATA_IN[0] && !MEAS_REQ_OUT && !SLEEP_OUT)
    |=> ##1 MEAS_REQ_OUT && !MEAS_OFFSET_OUT) else $error("colour run not started");
  offset_start_a: assert property (
    (ap_q && wr_q && idx_q == 7'h00 && HWDATA_IN[1:0] == 2'b10 && !MEAS_REQ_OUT && !SLEEP_OUT)
    |=> ##1 MEAS_REQ_OUT && MEAS_OFFSET_OUT) else $error("offset run not started");
  run_hold_a: assert property (
    MEAS_REQ_OUT && !MEAS_DONE_IN |=> MEAS_REQ_OUT && $stable(MEAS_OFFSET_OUT))
    else $error("run dropped early");
  run_end_a: assert property (
    MEAS_REQ_OUT && MEAS_DONE_IN |=> !MEAS_REQ_OUT) else $error("run not ended");
  mode_write_a: assert property (
    cfg_wr_s |=> EXT_TIMEBASE_OUT == $past(HWDATA_IN[2]) && TRIM_ENABLE_OUT == $past(HWDATA_IN[0]))
    else $error("mode bits wrong");
  sleep_clear_a: assert property (
    !EXT_TIMEBASE_OUT ##1 !EXT_TIMEBASE_OUT |-> !SLEEP_OUT) else $error("sleep kept");
  sleep_wait_a: assert property (
    SLEEP_OUT && !MEAS_REQ_OUT |=> !MEAS_REQ_OUT) else $error("run while asleep");
  gain_write_a: assert property (
    ap_q && wr_q && idx_q == 7'h06 |=> GAIN_OUT.red == $past(HWDATA_IN[3:0]))
    else $error("gain not stored");
  read_wait_a: assert property (
    ap_q && !wr_q |-> rd_wait_s) else $error("read timing wrong");
  rdata_hold_a: assert property (
    !(ap_q && !wr_q) && !(take && !HWRITE_IN) |=> $stable(HRDATA_OUT))
    else $error("read data moved");
  unused_zero_a: assert property (
    HRESP_OUT == 1'b0 && HRDATA_OUT[31:8] == 24'h0) else $error("upper bits or resp");
endmodule // csrb_top_assertions

bind csrb_top csrb_top_assertions u_csrb_chk (.CLK_SYS_IN, .RESETN_IN, .HSEL_IN, .HADDR_IN,
  .HTRANS_IN, .HWRITE_IN, .HREADY_IN, .HWDATA_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT,
  .MEAS_REQ_OUT, .MEAS_OFFSET_OUT, .MEAS_DONE_IN, .GAIN_OUT, .EXT_TIMEBASE_OUT, .SLEEP_OUT,
  .TRIM_ENABLE_OUT);

`default_nettype wire

/* sim/csrb_front_model.sv */
/*
  Front end model: answers a measurement request with a one-cycle done.
  Assumes the bench sets the latency and the values to return.
*/
`timescale 1ns/1ps
`default_nettype none

module csrb_front_model
  import csrb_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         req_in,
  input  wire logic         offset_in,
  input  wire logic [7:0]   lat_in,
  input  wire csrb_result_t res_val_in,
  input  wire csrb_offset_t ofs_val_in,
  output logic              done_out,
  output csrb_result_t      res_out,
  output csrb_offset_t      ofs_out
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q    <= 8'h00;
      done_out <= 1'b0;
    end else if (req_in && !done_out) begin
      cnt_q    <= cnt_q + 8'h01;
      done_out <= (cnt_q + 8'h01) >= lat_in;
    end else begin
      cnt_q    <= 8'h00;
      done_out <= 1'b0;
    end
  end
  // Outside done the lines show the inverse, so stale sampling is caught
  assign res_out = (done_out && !offset_in) ? res_val_in : csrb_result_t'(~res_val_in);
  assign ofs_out = (done_out && offset_in) ? ofs_val_in : csrb_offset_t'(~ofs_val_in);
endmodule // csrb_front_model

`default_nettype wire

/* sim/test_color_sensor_register_bank.sv */
/*
  Testbench of the colour sensor register bank over AHB-Lite.
  Assumes the front end model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module test_color_sensor_register_bank
  import csrb_pkg::*;
;
  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic         hsel    = 1'b0;
  logic [31:0]  haddr   = 32'h0;
  logic [1:0]   htrans  = 2'h0;
  logic         hwrite  = 1'b0;
  logic [31:0]  hwdata  = 32'h0;
  logic [7:0]   lat     = 8'h01;
  csrb_result_t res_val = '0;
  csrb_offset_t ofs_val = '0;
  logic [31:0]  hrdata;
  logic         hready;
  logic         req;
  logic         ofs_sel;
  logic         done;
  csrb_result_t res_w;
  csrb_offset_t ofs_w;
  csrb_gain_t   gain;
  csrb_slots_t  slots;
  logic         ext;
  logic         slp;
  logic         trim_o;
  logic         hresp;
  logic [9:0]   raw [4];
  logic [7:0]   off [4];
  int           error_cnt   = 0;
  int           comparisons = 0;

  always #5 clk = ~clk;

  csrb_top uut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready),
    .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .MEAS_REQ_OUT(req), .MEAS_OFFSET_OUT(ofs_sel), .MEAS_DONE_IN(done),
    .MEAS_RESULT_IN(res_w), .MEAS_OFFSET_IN(ofs_w), .GAIN_OUT(gain), .SLOTS_OUT(slots),
    .EXT_TIMEBASE_OUT(ext), .SLEEP_OUT(slp), .TRIM_ENABLE_OUT(trim_o));

  csrb_front_model u_front (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .offset_in(ofs_sel),
    .lat_in(lat), .res_val_in(res_val), .ofs_val_in(ofs_val), .done_out(done),
    .res_out(res_w), .ofs_out(ofs_w));

  // ---------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------
  function automatic logic [31:0] ra(input logic [6:0] i);
    return {23'h0, i, 2'h0};
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [31:0] rd;
    ahb(1'b1, ra(i), d, rd);
  endtask

  task automatic chk(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 8'h00, rd);
    comparisons++;
    if (rd !== {24'h0, exp}) begin
      error_cnt++;
      $display("ERROR %0t: addr %h read %h expected %h", $time, a, rd, exp);
    end
  endtask

  // Pin compare; call it a clock edge after the write so the value has settled
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: pin value %h expected %h", $time, got, exp);
    end
  endtask

  // Polls the trigger bits; a run that never ends is a mismatch
  task automatic wait_idle;
    logic [31:0] rd;
    int          n;
    n = 0;
    do begin
      ahb(1'b0, 32'h0, 8'h00, rd);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 100);
    comparisons++;
    if (n >= 100) begin
      error_cnt++;
      $display("ERROR %0t: trigger bits never cleared", $time);
    end
  endtask

  task automatic chk_res(input logic trim);
    logic [9:0] e;
    int         v;
    for (int c = 0; c < 4; c++) begin
      v = int'(raw[c]);
      if (trim) v = off[c][7] ? v + int'(off[c][6:0]) : v - int'(off[c][6:0]);
      v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
      e = 10'(v);
      chk(ra(7'(64 + 2 * c)), e[7:0]);
      chk(ra(7'(65 + 2 * c)), {6'h00, e[9:8]});
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    raw = '{10'h3A5, 10'h15A, 10'h2C3, 10'h040};
    off = '{8'hFF, 8'h03, 8'h85, 8'h7F};
    res_val <= {raw[0], raw[1], raw[2], raw[3]};
    ofs_val <= {off[0], off[1], off[2], off[3]};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp(48'(gain), 48'h00000000FFFF);
    cmp(slots, 48'h000000000000);
    for (int i = 0; i < 76; i++) chk(ra(7'(i)), (i > 5 && i < 10) ? 8'h0F : 8'h00);
    wr(7'h01, 8'hFF);
    chk(ra(7'h01), 8'h07);
    cmp(48'({ext, slp, trim_o}), 48'h000000000007);
    cmp(48'(hresp), 48'h000000000000);
    for (int i = 6; i < 18; i++) wr(7'(i), 8'hFF);
    for (int i = 6; i < 18; i++) chk(ra(7'(i)), (i < 10 || i[0]) ? 8'h0F : 8'hFF);
    wr(7'h0A, 8'h5A);
    wr(7'h11, 8'h03);
    wr(7'h06, 8'h02);
    @(posedge clk);
    cmp(slots, 48'hF5AFFFFFF3FF);
    cmp(48'(gain), 48'h000000002FFF);
    wr(7'h40, 8'hFF);
    chk(ra(7'h40), 8'h00);
    chk(32'h0000_0201, 8'h00);
    wr(7'h01, 8'h07);
    begin : unmapped_write
      logic [31:0] rd;
      ahb(1'b1, 32'h0000_0404, 8'h00, rd);
    end
    chk(ra(7'h01), 8'h07);
    // Asleep in external mode: the run must wait
    wr(7'h00, 8'h01);
    repeat (10) @(posedge clk);
    comparisons++;
    if (req !== 1'b0) begin
      error_cnt++;
      $display("ERROR %0t: run started while asleep", $time);
    end
    chk(ra(7'h00), 8'h01);
    wr(7'h01, 8'h03);
    chk(ra(7'h01), 8'h01);
    cmp(48'({ext, slp, trim_o}), 48'h000000000001);
    wait_idle();
    chk_res(1'b0);
    lat <= 8'd20;
    wr(7'h00, 8'h02);
    wait_idle();
    for (int c = 0; c < 4; c++) chk(ra(7'(72 + c)), off[c]);
    lat <= 8'd1;
    wr(7'h00, 8'h01);
    wait_idle();
    chk_res(1'b1);
    wr(7'h01, 8'h04);
    wr(7'h00, 8'h03);
    wait_idle();
    chk_res(1'b0);
    end_sim();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // test_color_sensor_register_bank

`default_nettype wire
